// *** logic/gpio_function_mux.sv ***
// General-purpose pins 00..08 multiplexer with boot strap capture.
// Assumes pins are synchronous to the core clock and that the caller
// resolves pad levels from the value and enable outputs.
`timescale 1ns/10ps
`default_nettype none
module gpio_function_mux (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire gpio_mux_pkg::pin_cfg_t [gpio_mux_pkg::NUM_PINS-1:0] i_pin_cfg,
   input wire logic [gpio_mux_pkg::NUM_PINS-1:0] i_pin_in,
   input wire logic i_aux_serial_clock,
   input wire logic i_aux_serial_out,
   input wire logic i_aux_serial_select_0_n,
   input wire logic i_aux_serial_select_1_n,
   input wire logic i_left_eye,
   input wire logic i_local_brightness_boost_hold,
   output logic [gpio_mux_pkg::NUM_PINS-1:0] o_pin_out,
   output logic [gpio_mux_pkg::NUM_PINS-1:0] o_pin_oe,
   output logic [gpio_mux_pkg::NUM_PINS-1:0] o_pin_read,
   output logic o_aux_serial_in,
   output logic o_micromirror_array_park,
   output logic o_host_projection_on,
   output logic [2:0] o_dsi_lanes,
   output logic o_strap_done
);
   import gpio_mux_pkg::*;

   // ------------------------------------------------------------
   // Alternate function routing
   // ------------------------------------------------------------
   alt_drive_t alt;
   logic [NUM_PINS-1:0] alt_val;
   logic [NUM_PINS-1:0] alt_drv;
   logic strap_done_q;

   assign alt.aux_serial_clock = i_aux_serial_clock;
   assign alt.aux_serial_out = i_aux_serial_out;
   assign alt.aux_serial_select_0_n = i_aux_serial_select_0_n;
   assign alt.aux_serial_select_1_n = i_aux_serial_select_1_n;
   assign alt.left_eye = i_left_eye;
   assign alt.boost_hold = i_local_brightness_boost_hold;

   function automatic logic is_alt(input pin_cfg_t c, input alt_sel_t a);
      is_alt = (c.mode == MODE_ALT) && (c.alt == a);
   endfunction : is_alt

   // Unused mode or alternate codes fall back to a plain input
   function automatic logic cfg_legal(input pin_cfg_t c);
      cfg_legal = (c.mode inside {MODE_INPUT, MODE_OUTPUT, MODE_BIDIR,
         MODE_OPEN_DRAIN, MODE_ALT}) && !(c.mode == MODE_ALT
         && c.alt == 2'h3);
   endfunction : cfg_legal

   // Alternate map (mode ALT):
   //   pin 00 FIRST: serial data in
   //   pin 01 FIRST: serial clock, only after strap capture
   //   pin 02 FIRST: serial data out, only after strap capture
   //   pin 03 FIRST: serial select 0, active low
   //   pin 04 FIRST: glasses shutter; SECOND: serial select 1
   //   pin 07 FIRST: brightness boost sample-hold
   //   pin 08 FIRST: park request in
   //   Any other choice drives nothing

   always_comb begin
      alt_val = '0;
      alt_drv = '0;
      // Serial master; strap pins wait until capture is over
      if (is_alt(i_pin_cfg[PIN_SER_CLK], ALT_FIRST) && strap_done_q) begin
         alt_val[PIN_SER_CLK] = alt.aux_serial_clock;
         alt_drv[PIN_SER_CLK] = 1'b1;
      end
      if (is_alt(i_pin_cfg[PIN_SER_OUT], ALT_FIRST) && strap_done_q) begin
         alt_val[PIN_SER_OUT] = alt.aux_serial_out;
         alt_drv[PIN_SER_OUT] = 1'b1;
      end
      // Selects pass through as given; idle high is the master's job
      if (is_alt(i_pin_cfg[PIN_SEL0], ALT_FIRST)) begin
         alt_val[PIN_SEL0] = alt.aux_serial_select_0_n;
         alt_drv[PIN_SEL0] = 1'b1;
      end
      if (is_alt(i_pin_cfg[PIN_SEL1], ALT_FIRST)) begin
         alt_val[PIN_SEL1] = alt.left_eye;
         alt_drv[PIN_SEL1] = 1'b1;
      end else if (is_alt(i_pin_cfg[PIN_SEL1], ALT_SECOND)) begin
         alt_val[PIN_SEL1] = alt.aux_serial_select_1_n;
         alt_drv[PIN_SEL1] = 1'b1;
      end
      if (is_alt(i_pin_cfg[PIN_BOOST], ALT_FIRST)) begin
         alt_val[PIN_BOOST] = alt.boost_hold;
         alt_drv[PIN_BOOST] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Pin cells
   // ------------------------------------------------------------
   pin_cfg_t [NUM_PINS-1:0] cfg_eff;

   generate
      for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
         // Strap pins stay inputs until the lane count is caught
         if (p == PIN_STRAP_LO || p == PIN_STRAP_HI) begin : g_strap
            assign cfg_eff[p] = (strap_done_q && cfg_legal(i_pin_cfg[p]))
               ? i_pin_cfg[p] : PIN_CFG_RST;
         end else begin : g_plain
            assign cfg_eff[p] = cfg_legal(i_pin_cfg[p]) ? i_pin_cfg[p]
               : PIN_CFG_RST;
         end
         gpio_pin_cell u_cell (
            .i_core_clk(i_core_clk),
            .i_reset_n(i_reset_n),
            .i_cfg(cfg_eff[p]),
            .i_alt_val(alt_val[p]),
            .i_alt_drive(alt_drv[p]),
            .o_val(o_pin_out[p]),
            .o_oe(o_pin_oe[p])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Input readback and serial input
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pin_read <= PINS_RST;
      end else begin
         o_pin_read <= i_pin_in;
      end
   end

   // Reads zero unless pin 00 carries the serial input
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_aux_serial_in <= 1'b0;
      end else if (is_alt(i_pin_cfg[PIN_SER_IN], ALT_FIRST)) begin
         o_aux_serial_in <= i_pin_in[PIN_SER_IN];
      end else begin
         o_aux_serial_in <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Park request
   // ------------------------------------------------------------
   // Host keeps each level 200 ms, so no filtering here
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_host_projection_on <= 1'b0;
      end else begin
         o_host_projection_on <= i_pin_in[PIN_PARK];
      end
   end

   // Park only; array power is handled outside
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_micromirror_array_park <= 1'b0;
      end else begin
         o_micromirror_array_park <= is_alt(i_pin_cfg[PIN_PARK], ALT_FIRST)
            && !i_pin_in[PIN_PARK];
      end
   end

   // ------------------------------------------------------------
   // Boot strap capture
   // ------------------------------------------------------------
   logic [5:0] strap_cnt_q;
   logic settle_end;

   // Lane count from the two strap levels, high pin first
   function automatic logic [2:0] strap_lanes(input logic hi,
      input logic lo);
      strap_lanes = {1'b0, hi, lo} + 3'h1;
   endfunction : strap_lanes

   assign settle_end = !strap_done_q
      && (strap_cnt_q == 6'(STRAP_SETTLE_CYC - 1));

   // Settle counter freezes once the straps are caught
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         strap_cnt_q <= STRAP_CNT_RST;
      end else if (!strap_done_q && !settle_end) begin
         strap_cnt_q <= strap_cnt_q + 6'h01;
      end
   end

   // Single capture; later pad activity never moves the lane count
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_dsi_lanes <= LANES_RST;
      end else if (settle_end) begin
         o_dsi_lanes <= strap_lanes(i_pin_in[PIN_STRAP_HI],
            i_pin_in[PIN_STRAP_LO]);
      end
   end

   // Internal copy gates the strap pins, the port copy tells the user
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         strap_done_q <= 1'b0;
         o_strap_done <= 1'b0;
      end else if (settle_end) begin
         strap_done_q <= 1'b1;
         o_strap_done <= 1'b1;
      end
   end

endmodule : gpio_function_mux
`default_nettype wire

// *** common/gpio_mux_pkg.sv ***
// Shared types and constants for the general-purpose pin multiplexer.
// Assumes one 40 MHz system clock and an active-low asynchronous reset.
package gpio_mux_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_PINS = 9;
   localparam int SEL_W = 2;

   // ------------------------------------------------------------
   // Pin indices
   // ------------------------------------------------------------
   localparam int PIN_SER_IN = 0;
   localparam int PIN_SER_CLK = 1;
   localparam int PIN_SER_OUT = 2;
   localparam int PIN_SEL0 = 3;
   localparam int PIN_SEL1 = 4;
   localparam int PIN_BOOST = 7;
   localparam int PIN_PARK = 8;
   localparam int PIN_STRAP_LO = 1;
   localparam int PIN_STRAP_HI = 2;

   // ------------------------------------------------------------
   // Timing and reset values
   // ------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int STRAP_SETTLE_NS = 1000;
   localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * (CLK_HZ / 1_000_000)
      + 999) / 1000;
   localparam logic [5:0] STRAP_CNT_RST = 6'h00;
   localparam logic [2:0] LANES_RST = 3'h1;
   localparam logic [NUM_PINS-1:0] PINS_RST = 9'h000;

   // ------------------------------------------------------------
   // Per-pin mode
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_INPUT = 3'b000,
      MODE_OUTPUT = 3'b001,
      MODE_BIDIR = 3'b010,
      MODE_OPEN_DRAIN = 3'b011,
      MODE_ALT = 3'b100
   } pin_mode_t;

   // Alternate function choice, per pin meaning
   typedef enum logic [1:0] {
      ALT_NONE = 2'b00,
      ALT_FIRST = 2'b01,
      ALT_SECOND = 2'b10
   } alt_sel_t;

   typedef struct packed {
      pin_mode_t mode;
      alt_sel_t alt;
      logic out_val;
      logic out_en;
   } pin_cfg_t;

   localparam pin_cfg_t PIN_CFG_RST = '{MODE_INPUT, ALT_NONE, 1'b0, 1'b0};

   // Internal function-side signals that ride the alternate paths
   typedef struct packed {
      logic aux_serial_clock;
      logic aux_serial_out;
      logic aux_serial_select_0_n;
      logic aux_serial_select_1_n;
      logic left_eye;
      logic boost_hold;
   } alt_drive_t;

endpackage : gpio_mux_pkg

// *** logic/gpio_pin_cell.sv ***
// One pin's output path: mode decode, output and enable registers.
// Assumes config and alternate drive are synchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_cell (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire gpio_mux_pkg::pin_cfg_t i_cfg,
   input wire logic i_alt_val,
   input wire logic i_alt_drive,
   output logic o_val,
   output logic o_oe
);
   import gpio_mux_pkg::*;

   logic val_d;
   logic oe_d;

   always_comb begin
      val_d = 1'b0;
      oe_d = 1'b0;
      unique case (i_cfg.mode)
         MODE_INPUT: begin
            val_d = 1'b0;
            oe_d = 1'b0;
         end
         MODE_OUTPUT: begin
            val_d = i_cfg.out_val;
            oe_d = 1'b1;
         end
         MODE_BIDIR: begin
            val_d = i_cfg.out_val;
            oe_d = i_cfg.out_en;
         end
         MODE_OPEN_DRAIN: begin
            // Only ever pulls low; the board pull-up gives the high
            val_d = 1'b0;
            oe_d = ~i_cfg.out_val;
         end
         MODE_ALT: begin
            val_d = i_alt_val;
            oe_d = i_alt_drive;
         end
         default: begin
            val_d = 1'b0;
            oe_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_val <= 1'b0;
         o_oe <= 1'b0;
      end else begin
         o_val <= val_d;
         o_oe <= oe_d;
      end
   end

endmodule : gpio_pin_cell
`default_nettype wire

// *** tb/gpio_mux_checker.sv ***
// Port assertions for the general-purpose pin multiplexer.
// Assumes a bind onto gpio_function_mux.
`timescale 1ns/10ps
`default_nettype none
module gpio_mux_checker (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire gpio_mux_pkg::pin_cfg_t [8:0] i_pin_cfg,
   input wire logic [8:0] i_pin_in,
   input wire logic i_aux_serial_clock,
   input wire logic i_aux_serial_select_0_n,
   input wire logic i_left_eye,
   input wire logic [8:0] o_pin_out,
   input wire logic [8:0] o_pin_oe,
   input wire logic o_aux_serial_in,
   input wire logic o_micromirror_array_park,
   input wire logic [2:0] o_dsi_lanes,
   input wire logic o_strap_done
);
   import gpio_mux_pkg::*;
   function automatic logic alt(pin_cfg_t c, alt_sel_t a);
      return c.mode == MODE_ALT && c.alt == a;
   endfunction : alt
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   // Strap done doubles as a guard well clear of reset release
   a_park_request: assert property (
      o_strap_done && alt(i_pin_cfg[8], ALT_FIRST) && !i_pin_in[8]
      |=> o_micromirror_array_park) else $error("park not raised");
   a_park_release: assert property (
      o_strap_done && i_pin_in[8] |=> !o_micromirror_array_park)
      else $error("park while request high");
   a_reset_input: assert property (disable iff (1'b0)
      !i_reset_n |-> o_pin_oe == 9'h000) else $error("pin driven in reset");
   a_shutter_eye: assert property (
      o_strap_done && alt(i_pin_cfg[4], ALT_FIRST) |=> o_pin_oe[4]
      && o_pin_out[4] == $past(i_left_eye)) else $error("shutter wrong");
   a_select_zero: assert property (
      o_strap_done && alt(i_pin_cfg[3], ALT_FIRST) |=> o_pin_oe[3]
      && o_pin_out[3] == $past(i_aux_serial_select_0_n))
      else $error("select 0 wrong");
   a_serial_clock: assert property (
      o_strap_done && alt(i_pin_cfg[1], ALT_FIRST) |=> o_pin_oe[1]
      && o_pin_out[1] == $past(i_aux_serial_clock)) else $error("sclk wrong");
   a_serial_in: assert property (
      o_strap_done && alt(i_pin_cfg[0], ALT_FIRST)
      |=> o_aux_serial_in == $past(i_pin_in[0])) else $error("sdin wrong");
   a_strap_lanes: assert property (
      $rose(o_strap_done) |-> o_dsi_lanes ==
      {$past(i_pin_in[2]), $past(i_pin_in[1])} + 3'h1) else $error("lanes");
   c_park: cover property (o_micromirror_array_park);
   c_four_lanes: cover property ($rose(o_strap_done) && o_dsi_lanes == 3'h4);
   c_shutter: cover property (o_pin_oe[4] && o_pin_out[4]);
endmodule : gpio_mux_checker
`default_nettype wire

// *** tb/gpio_far_side.sv ***
// Far side of the pins: host park request, lane straps, serial peripheral.
// Assumes a pad follows the device whenever its enable is high.
`timescale 1ns/10ps
`default_nettype none
module gpio_far_side #(
   parameter int PARK_HOLD = 50
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic [1:0] i_strap,
   input wire logic [8:0] i_pad_out,
   input wire logic [8:0] i_pad_oe,
   output logic [8:0] o_pad
);
   int cnt_q;
   logic park_q;
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= 0;
         park_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1;
         // Long host hold scaled down to PARK_HOLD cycles
         if (cnt_q % PARK_HOLD == PARK_HOLD - 1) park_q <= ~park_q;
      end
   end
   // Undriven pads other than the two straps toggle so a stale level never passes for a drive
   assign o_pad = (i_pad_oe & i_pad_out) | (~i_pad_oe & {park_q,
      {5{cnt_q[0]}}, i_strap, cnt_q[1] ^ cnt_q[3]});
endmodule : gpio_far_side
`default_nettype wire

// *** tb/gpio_function_mux_bench.sv ***
// Self-checking bench for the pin multiplexer with a reference model.
// Assumes gpio_far_side on the pads and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module gpio_function_mux_bench;
   import gpio_mux_pkg::*;
   logic core_clk = 1'b0;
   // Starts high so the first reset is a real falling edge
   logic reset_n = 1'b1;
   logic [1:0] strap = 2'h0;
   pin_cfg_t [8:0] cfg = '0;
   alt_drive_t drv = '0;
   logic [8:0] pad, pout, poe, prd, rd_e, oe_e, out_e, m;
   logic sin, park, proj, done, sin_e, park_e;
   logic [2:0] lanes;
   int seed = 32'h5559;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   int r;
   always #12.5 core_clk = ~core_clk;
   gpio_function_mux u_dut (.i_core_clk(core_clk), .i_reset_n(reset_n),
      .i_pin_cfg(cfg), .i_pin_in(pad),
      .i_aux_serial_clock(drv.aux_serial_clock),
      .i_aux_serial_out(drv.aux_serial_out),
      .i_aux_serial_select_0_n(drv.aux_serial_select_0_n),
      .i_aux_serial_select_1_n(drv.aux_serial_select_1_n),
      .i_left_eye(drv.left_eye),
      .i_local_brightness_boost_hold(drv.boost_hold), .o_pin_out(pout),
      .o_pin_oe(poe), .o_pin_read(prd), .o_aux_serial_in(sin),
      .o_micromirror_array_park(park), .o_host_projection_on(proj),
      .o_dsi_lanes(lanes), .o_strap_done(done));
   gpio_far_side u_far (.i_core_clk(core_clk), .i_reset_n(reset_n),
      .i_strap(strap), .i_pad_out(pout), .i_pad_oe(poe), .o_pad(pad));
   task automatic chk(string n, logic [8:0] e, logic [8:0] s);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic chk_bit(string n, logic e, logic s);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %b seen %b", n, e, s);
      end
   endtask : chk_bit
   task automatic chk_lanes(string n, logic [2:0] e, logic [2:0] s);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %0d seen %0d", n, e, s);
      end
   endtask : chk_lanes
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   // Returns {value, enable} for one pad
   function automatic logic [1:0] pin_m(int p, pin_cfg_t c, alt_drive_t d);
      logic f;
      f = c.alt == ALT_FIRST;
      case (c.mode)
         MODE_OUTPUT: return {c.out_val, 1'b1};
         MODE_BIDIR: return {c.out_val, c.out_en};
         MODE_OPEN_DRAIN: return {1'b0, ~c.out_val};
         MODE_ALT: begin
            if (f && p == 1) return {d.aux_serial_clock, 1'b1};
            if (f && p == 2) return {d.aux_serial_out, 1'b1};
            if (f && p == 3) return {d.aux_serial_select_0_n, 1'b1};
            if (f && p == 4) return {d.left_eye, 1'b1};
            if (c.alt == ALT_SECOND && p == 4)
               return {d.aux_serial_select_1_n, 1'b1};
            if (f && p == 7) return {d.boost_hold, 1'b1};
            return 2'b00;
         end
         default: return 2'b00;
      endcase
   endfunction : pin_m
   always @(posedge core_clk) begin
      cyc <= reset_n ? cyc + 1 : 0;
      if (reset_n && cyc > 2) begin
         for (int p = 0; p < 9; p++)
            {out_e[p], oe_e[p]} = (p inside {1, 2} && cyc < 40) ? 2'b00
               : pin_m(p, cfg[p], drv);
         // Strap pins unchecked near the capture edge
         m = (cyc > 35 && cyc < 48) ? 9'h1F9 : 9'h1FF;
         sin_e = cfg[0].mode == MODE_ALT && cfg[0].alt == ALT_FIRST && pad[0];
         park_e = cfg[8].mode == MODE_ALT && cfg[8].alt == ALT_FIRST && !pad[8];
         rd_e = pad;
         @(negedge core_clk);
         if (reset_n) begin
            chk("oe", oe_e & m, poe & m);
            chk("out", out_e & oe_e & m, pout & oe_e & m);
            chk("read", rd_e, prd);
            chk_bit("serial_in", sin_e, sin);
            chk_bit("park", park_e, park);
            chk_bit("projection", rd_e[8], proj);
            chk_bit("strap_done", cyc >= STRAP_SETTLE_CYC, done);
            chk_lanes("lanes_live", cyc >= STRAP_SETTLE_CYC
               ? {1'b0, strap} + 3'h1 : LANES_RST, lanes);
         end
      end
   end
   initial begin
      for (int s = 0; s < 4; s++) begin
         reset_n <= 1'b0;
         strap <= 2'(s);
         repeat (3) @(posedge core_clk);
         reset_n <= 1'b1;
         repeat (300) begin
            @(posedge core_clk);
            drv <= alt_drive_t'(6'($random(seed)));
            for (int p = 0; p < 9; p++) begin
               r = $random(seed);
               if (r[3:0] == 4'h0)
                  cfg[p] <= '{pin_mode_t'(3'(r[31:8] % 5)),
                     alt_sel_t'(2'(r[7:4] % 3)), r[5], r[6]};
            end
         end
         chk_lanes("lanes", 3'(s + 1), lanes);
      end
      stop_test();
   end
   initial begin
      #100us;
      miscompares++;
      stop_test();
   end
endmodule : gpio_function_mux_bench
bind gpio_function_mux gpio_mux_checker u_chk (.i_core_clk, .i_reset_n,
   .i_pin_cfg, .i_pin_in, .i_aux_serial_clock, .i_aux_serial_select_0_n,
   .i_left_eye, .o_pin_out, .o_pin_oe, .o_aux_serial_in,
   .o_micromirror_array_park, .o_dsi_lanes, .o_strap_done);
`default_nettype wire
